// >>> msr_host.sv
// SPI host model, mode 0, MSB first, 160 ns link clock.
// Assumes a 10 ns ref_clk to pace its edges.
`timescale 1ns/1ps
module msr_host (
  input wire logic ref_clk,
  input wire logic sdo,
  output logic sclk,
  output logic cs_n,
  output logic sdi
);
  // Idle link: clock still, not selected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // One frame of n bits from the top of v; read byte from bits 8..15
  task automatic xfer(input logic [47:0] v, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge ref_clk);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = v[47 - i];
      repeat (8) @(negedge ref_clk);
      sclk = 1'b1;
      if (i >= 8 && i < 16) begin
        rd = {rd[6:0], sdo};
      end
      repeat (8) @(negedge ref_clk);
      sclk = 1'b0;
    end
    repeat (8) @(negedge ref_clk);
    cs_n = 1'b1;
    sdi = ~sdi;
    repeat (12) @(negedge ref_clk);
  endtask
endmodule

// >>> msr_pkg.sv
// Shared constants and types for the mux select and SPI error block.
// Assumes an SPI frame of an 8-bit command byte and an 8-bit data byte.
package msr_pkg;

  // Register addresses
  localparam logic [6:0] ADDR_SWITCH = 7'h01;
  localparam logic [6:0] ADDR_CFG = 7'h02;
  localparam logic [6:0] ADDR_FLAGS = 7'h03;
  localparam logic [6:0] ADDR_BURST = 7'h05;

  // Reset values
  localparam logic [7:0] RST_SWITCH = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h06;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_BURST = 8'h00;

  // Writable bit masks; reserved bits stay zero
  localparam logic [7:0] CFG_WMASK = 8'h07;
  localparam logic [7:0] BURST_WMASK = 8'h01;
  localparam logic [7:0] FLAGS_ALL = 8'h07;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Special command that clears every flag
  localparam logic [15:0] CLEAR_CMD = 16'h6CA9;

  // Bit positions within one command, last bit of each phase
  localparam logic [4:0] POS_ZERO = 5'h00;
  localparam logic [4:0] POS_ADDR_LAST = 5'h07;
  localparam logic [4:0] POS_CMD_LAST = 5'h0F;
  localparam logic [4:0] POS_CRC_LAST = 5'h17;

  // CRC-8 over the 16 command bits, MSB first
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // Completed command counter values
  localparam logic [1:0] CMDS_NONE = 2'h0;
  localparam logic [1:0] CMDS_ONE = 2'h1;
  localparam logic [1:0] CMDS_MAX = 2'h3;

  // Synchroniser reset value, order {sdi, sclk, cs_n}
  localparam logic [2:0] SYNC_RST = 3'h1;

  // One command word
  typedef struct packed {
    logic rd;
    logic [6:0] addr;
    logic [7:0] data;
  } msr_cmd_s;

  // Error check configuration
  typedef struct packed {
    logic [4:0] rsvd;
    logic rw_en;
    logic sclk_en;
    logic crc_en;
  } msr_cfg_s;

  // Error flags
  typedef struct packed {
    logic [4:0] rsvd;
    logic rw_err;
    logic sclk_err;
    logic crc_err;
  } msr_flags_s;

  // Switch select word, eight-channel layout
  typedef struct packed {
    logic [3:0] general_output;
    logic select_bit_2;
    logic select_bit_1;
    logic select_bit_0;
    logic enable;
  } msr_sw8_s;

  // Switch select word, dual four-channel layout
  typedef struct packed {
    logic [4:0] general_output;
    logic select_bit_1;
    logic select_bit_0;
    logic enable;
  } msr_sw4_s;

  // Frame state
  typedef enum logic [1:0] {
    MSR_IDLE = 2'b01,
    MSR_FRAME = 2'b10
  } msr_state_e;

endpackage

// >>> msr_sync.sv
// Two-flop synchroniser for the SPI pins.
// Assumes the pins are asynchronous to ref_clk.
`timescale 1ns/1ps
module msr_sync
  import msr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [2:0] async_in,
  output logic [2:0] sync_out
);

  // First stage, read only by the second stage
  logic [2:0] meta_r;

  // Two flops per bit
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_bit
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          meta_r[i] <= SYNC_RST[i];
          sync_out[i] <= SYNC_RST[i];
        end else begin
          meta_r[i] <= async_in[i];
          sync_out[i] <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule

// >>> msr_top.sv
// SPI register bank with mux select decode and error detection.
// Assumes an SPI host in mode 0 or 3, SCLK far slower than ref_clk.
//
// Overview of operation
// - Eight-channel: enable plus select closes one switch
// - Dual variant: enable plus select closes one pair
// - Config bit 2 enables address error detection
// - Config bit 1 enables SCLK count checking
// - No CRC, no burst: 16 clocks exactly
// - CRC, no burst: 24 clocks exactly
// - Burst: whole multiples of command length only
// - Config bit 0 enables CRC, 24-bit commands
// - Config at 0x02, resets to 0x06
// - Command 0x6CA9 clears all flags
// - Clear command never raises address error
// - With CRC on, clear needs correct CRC
// - Read of missing address sets bit 2
// - Write to missing or read-only sets bit 2
// - Wrong clock count sets flag bit 1
// - Bad CRC on write sets flag bit 0
// - Flags at 0x03, read-only, reset 0x00
// - Switch word at 0x01, enable, select, outputs
// - Burst allows several commands per frame
`timescale 1ns/1ps
module msr_top
  import msr_pkg::*;
#(
  parameter bit DUAL_VARIANT = 1'b0
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  output logic [7:0] switch_on,
  output logic [4:0] general_outputs
);

  // Readable register addresses
  function automatic logic addr_readable(input logic [6:0] a);
    addr_readable = (a == ADDR_SWITCH) || (a == ADDR_CFG) ||
                    (a == ADDR_FLAGS) || (a == ADDR_BURST);
  endfunction

  // Writable register addresses; flags are read-only
  function automatic logic addr_writable(input logic [6:0] a);
    addr_writable = (a == ADDR_SWITCH) || (a == ADDR_CFG) ||
                    (a == ADDR_BURST);
  endfunction

  // One serial CRC-8 step
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[7] ^ b;
    crc_step = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : BYTE_ZERO);
  endfunction

  // Synchronised pins
  logic [2:0] pins_s;
  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;

  // Edge history
  logic sclk_d_r;
  logic cs_n_d_r;

  // Frame state
  msr_state_e state_r;
  msr_state_e state_nxt;

  // Receive path
  logic [23:0] shift_r;
  logic [23:0] shift_nxt;
  logic [4:0] bit_pos_r;
  logic [7:0] crc_r;
  logic [1:0] cmds_r;

  // Transmit path
  logic [7:0] tx_r;
  logic sdo_r;
  logic sdo_oe_r;

  // Command held until the frame closes
  logic pend_valid_r;
  msr_cmd_s pend_cmd_r;

  // Registers
  logic [7:0] sw_word_r;
  msr_cfg_s cfg_r;
  msr_flags_s flags_r;
  logic [7:0] burst_r;
  logic [7:0] switch_on_r;
  logic [4:0] gpo_r;

  // Pin synchroniser
  msr_sync u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_in({sdi, sclk, cs_n}),
    .sync_out(pins_s)
  );

  assign cs_n_s = pins_s[0];
  assign sclk_s = pins_s[1];
  assign sdi_s = pins_s[2];

  // Edge detection on synchronised pins
  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire sclk_fall = ~sclk_s & sclk_d_r;
  wire cs_fall = ~cs_n_s & cs_n_d_r;
  wire cs_rise = cs_n_s & ~cs_n_d_r;

  // Frame qualifiers
  wire in_frame = (state_r == MSR_FRAME);
  wire bit_take = in_frame & sclk_rise;
  wire frame_end = in_frame & cs_rise;
  wire burst_en = burst_r[0];

  // Command length follows the CRC setting
  wire [4:0] pos_last = cfg_r.crc_en ? POS_CRC_LAST : POS_CMD_LAST;
  wire last_bit = bit_take & (bit_pos_r == pos_last);
  wire addr_done = bit_take & (bit_pos_r == POS_ADDR_LAST);
  wire crc_phase = (bit_pos_r <= POS_CMD_LAST);

  // Shifted word including the bit now taken
  assign shift_nxt = {shift_r[22:0], sdi_s};

  // Command and received CRC of the completed command
  wire [15:0] cmd_bits = cfg_r.crc_en ? shift_nxt[23:8] : shift_nxt[15:0];
  wire [7:0] rx_crc = shift_nxt[7:0];
  msr_cmd_s cmd_w;
  assign cmd_w = msr_cmd_s'(cmd_bits);

  // Command classification
  wire is_clear = (cmd_bits == CLEAR_CMD);
  wire crc_bad = cfg_r.crc_en & (rx_crc != crc_r);
  wire rd_ok = addr_readable(cmd_w.addr);
  wire wr_ok = addr_writable(cmd_w.addr);

  // Address error; clear command exempt
  wire addr_bad = cmd_w.rd ? ~rd_ok : (~wr_ok & ~is_clear);

  // Command that may act: good CRC write or clear
  wire act_ok = ~cmd_w.rd & ~crc_bad & (wr_ok | is_clear);

  // Clock count check at frame end
  wire one_cmd = (cmds_r == CMDS_ONE);
  wire some_cmd = (cmds_r != CMDS_NONE);
  wire whole_cmds = (bit_pos_r == POS_ZERO);
  wire count_ok = whole_cmds & (burst_en ? some_cmd : one_cmd);
  wire end_ok = count_ok | ~cfg_r.sclk_en;

  // Commit: burst acts per command, otherwise at frame end
  wire commit_now = last_bit & act_ok & burst_en;
  wire commit_end = frame_end & end_ok & pend_valid_r;
  wire do_commit = commit_now | commit_end;
  msr_cmd_s commit_cmd;
  assign commit_cmd = commit_now ? cmd_w : pend_cmd_r;
  wire commit_clear = (commit_cmd == msr_cmd_s'(CLEAR_CMD));
  wire do_clear = do_commit & commit_clear;
  wire do_write = do_commit & ~commit_clear;

  // Per-register write strobes
  wire wr_switch = do_write & (commit_cmd.addr == ADDR_SWITCH);
  wire wr_cfg = do_write & (commit_cmd.addr == ADDR_CFG);
  wire wr_burst = do_write & (commit_cmd.addr == ADDR_BURST);

  // Flag set events, each gated by its enable
  wire set_rw = last_bit & addr_bad & cfg_r.rw_en;
  wire set_sclk = frame_end & ~count_ok & cfg_r.sclk_en;
  wire set_crc = last_bit & ~cmd_w.rd & crc_bad;

  // Flag update; a set wins over a clear in the same cycle
  msr_flags_s flag_set;
  assign flag_set = '{rsvd: '0, rw_err: set_rw, sclk_err: set_sclk, crc_err: set_crc};
  wire [7:0] flag_clr = do_clear ? FLAGS_ALL : BYTE_ZERO;
  wire [7:0] flags_nxt = ((flags_r & ~flag_clr) | flag_set) & FLAGS_ALL;

  // Read data for the address now received
  wire [6:0] rd_addr = shift_nxt[6:0];
  wire rd_cmd = shift_nxt[7];
  wire [7:0] rd_data =
    (rd_addr == ADDR_SWITCH) ? sw_word_r :
    (rd_addr == ADDR_CFG) ? cfg_r :
    (rd_addr == ADDR_FLAGS) ? flags_r :
    (rd_addr == ADDR_BURST) ? burst_r : BYTE_ZERO;
  wire [7:0] tx_load = rd_cmd ? rd_data : BYTE_ZERO;

  // Switch word views per variant
  msr_sw8_s w8;
  msr_sw4_s w4;
  assign w8 = msr_sw8_s'(sw_word_r);
  assign w4 = msr_sw4_s'(sw_word_r);

  // Select value and enable
  wire [2:0] sel_val = DUAL_VARIANT ? {1'b0, w4.select_bit_1, w4.select_bit_0}
                                    : {w8.select_bit_2, w8.select_bit_1, w8.select_bit_0};
  wire sw_enable = w8.enable;
  wire [4:0] gpo_val = DUAL_VARIANT ? w4.general_output : {1'b0, w8.general_output};

  // One-hot switch decode
  logic [7:0] sw_dec;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_dec
      assign sw_dec[gi] = sw_enable & (sel_val == 3'(gi));
    end
  endgenerate

  // Next frame state
  always_comb begin
    case (state_r)
      MSR_IDLE: state_nxt = cs_fall ? MSR_FRAME : MSR_IDLE;
      MSR_FRAME: state_nxt = cs_rise ? MSR_IDLE : MSR_FRAME;
      default: state_nxt = MSR_IDLE;
    endcase
  end

  // Edge history and state
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
      state_r <= MSR_IDLE;
    end else begin
      sclk_d_r <= sclk_s;
      cs_n_d_r <= cs_n_s;
      state_r <= state_nxt;
    end
  end

  // Shift register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      shift_r <= '0;
    end else if (bit_take) begin
      shift_r <= shift_nxt;
    end
  end

  // Bit position within the current command
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bit_pos_r <= POS_ZERO;
    end else if (cs_fall || last_bit) begin
      bit_pos_r <= POS_ZERO;
    end else if (bit_take) begin
      bit_pos_r <= bit_pos_r + 5'h01;
    end
  end

  // Running CRC over the command bits
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      crc_r <= CRC_INIT;
    end else if (cs_fall || last_bit) begin
      crc_r <= CRC_INIT;
    end else if (bit_take && crc_phase) begin
      crc_r <= crc_step(crc_r, sdi_s);
    end
  end

  // Completed commands in this frame, saturating
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmds_r <= CMDS_NONE;
    end else if (cs_fall) begin
      cmds_r <= CMDS_NONE;
    end else if (last_bit && cmds_r != CMDS_MAX) begin
      cmds_r <= cmds_r + 2'h1;
    end
  end

  // Held command for non-burst frames
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pend_valid_r <= 1'b0;
      pend_cmd_r <= '0;
    end else if (cs_fall || frame_end) begin
      pend_valid_r <= 1'b0;
    end else if (last_bit) begin
      pend_valid_r <= act_ok & ~burst_en;
      pend_cmd_r <= cmd_w;
    end
  end

  // Transmit shifter; data byte moves out on falling edges
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_r <= BYTE_ZERO;
      sdo_r <= 1'b0;
    end else if (cs_fall) begin
      tx_r <= BYTE_ZERO;
      sdo_r <= 1'b0;
    end else if (addr_done) begin
      tx_r <= tx_load;
    end else if (in_frame && sclk_fall) begin
      sdo_r <= tx_r[7];
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // Data out is driven only inside a frame
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sdo_oe_r <= 1'b0;
    end else begin
      sdo_oe_r <= ~cs_n_s;
    end
  end

  // Switch select word
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sw_word_r <= RST_SWITCH;
    end else if (wr_switch) begin
      sw_word_r <= commit_cmd.data;
    end
  end

  // Error check configuration; reserved bits held zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= RST_CFG;
    end else if (wr_cfg) begin
      cfg_r <= commit_cmd.data & CFG_WMASK;
    end
  end

  // Burst enable
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      burst_r <= RST_BURST;
    end else if (wr_burst) begin
      burst_r <= commit_cmd.data & BURST_WMASK;
    end
  end

  // Sticky error flags, never written directly
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flags_r <= RST_FLAGS;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Registered switch and general outputs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      switch_on_r <= BYTE_ZERO;
      gpo_r <= '0;
    end else begin
      switch_on_r <= sw_dec;
      gpo_r <= gpo_val;
    end
  end

  // Outputs
  assign sdo = sdo_r;
  assign sdo_oe = sdo_oe_r;
  assign switch_on = switch_on_r;
  assign general_outputs = gpo_r;

endmodule

// >>> msr_top_asserts.sv
// Port checker for the mux select and SPI error block.
// Assumes it is bound onto every msr_top instance.
`timescale 1ns/1ps
module msr_top_asserts #(
  parameter bit DUAL_VARIANT = 1'b0
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic [7:0] switch_on,
  input wire logic [4:0] general_outputs
);
  // One clock domain, async reset
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  one_switch_a: assert property ($onehot0(switch_on))
    else $error("more than one switch closed");
  pair_range_a: assert property (!DUAL_VARIANT || switch_on[7:4] == 4'h0)
    else $error("dual variant closed a missing pair");
  gpo_width_a: assert property (DUAL_VARIANT || !general_outputs[4])
    else $error("eight-channel top output bit set");
  reset_value_a: assert property ($rose(rstn) |-> switch_on == 8'h00 && general_outputs == 5'h00)
    else $error("outputs not at reset value");
  drive_start_a: assert property ($fell(cs_n) |-> ##[2:4] sdo_oe)
    else $error("sdo not driven in frame");
  drive_stop_a: assert property (cs_n [*5] |-> !sdo_oe)
    else $error("sdo driven outside frame");
  sdo_hold_a: assert property ((sclk && !cs_n) [*4] |-> $stable(sdo))
    else $error("sdo moved while clock high");
  idle_hold_a: assert property (cs_n [*8] |-> $stable(switch_on) && $stable(general_outputs))
    else $error("outputs moved between frames");
  low_hold_a: assert property ((!sclk && !cs_n) [*6] |-> $stable(switch_on))
    else $error("switch moved mid bit");
endmodule

bind msr_top msr_top_asserts #(.DUAL_VARIANT(DUAL_VARIANT)) msr_top_asserts_i (
  .ref_clk, .rstn, .sclk, .cs_n, .sdi, .sdo, .sdo_oe, .switch_on, .general_outputs
);

// >>> msr_top_tb.sv
// Self-checking bench, both variants on one SPI link.
// Assumes the host model in msr_host.sv.
`timescale 1ns/1ps
module msr_top_tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic sclk, cs_n, sdi, sdo;
  logic [7:0] sw8, sw4, r;
  logic [4:0] go8, go4;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int fl = 16;

  always #5 ref_clk = ~ref_clk;

  msr_host msr_host_i (.ref_clk(ref_clk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
  msr_top #(.DUAL_VARIANT(1'b0)) msr_top_i (.ref_clk(ref_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(), .switch_on(sw8), .general_outputs(go8));
  msr_top #(.DUAL_VARIANT(1'b1)) msr_top_dual_i (.ref_clk(ref_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo(), .sdo_oe(), .switch_on(sw4), .general_outputs(go4));

  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // CRC-8, poly 0x07, init 0, MSB first
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // Frame helpers; bad flips the CRC byte
  task automatic frm(input logic [15:0] w, input int n, input logic [7:0] bad);
    msr_host_i.xfer({w, crc8(w) ^ bad, 24'h000000}, n, r);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    frm({1'b0, a, d}, fl, 8'h00);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    frm({1'b1, a, 8'h00}, fl, 8'h00);
    chk(r, e);
  endtask
  task automatic clr(input logic [7:0] bad);
    frm(16'h6CA9, fl, bad);
  endtask
  // Both variants against one switch word
  task automatic swc(input logic [7:0] w);
    chk(sw8, w[0] ? 8'h01 << w[3:1] : 8'h00);
    chk(sw4, w[0] ? 8'h01 << w[2:1] : 8'h00);
    chk({3'h0, go8}, {4'h0, w[7:4]});
    chk({3'h0, go4}, {3'h0, w[7:3]});
  endtask

  task automatic t_reset();
    rdc(7'h01, 8'h00);
    rdc(7'h02, 8'h06);
    rdc(7'h03, 8'h00);
    swc(8'h00);
    $display("t_reset done");
  endtask

  task automatic t_switch();
    logic [7:0] w;
    for (int i = 0; i < 8; i++) begin
      w = {i[2:0], 1'b1, i[2:0], 1'b1};
      wr(7'h01, w);
      swc(w);
    end
    wr(7'h01, 8'hFE);
    swc(8'hFE);
    rdc(7'h01, 8'hFE);
    $display("t_switch done");
  endtask

  task automatic t_addr();
    frm(16'h8400, 16, 8'h00);
    rdc(7'h03, 8'h04);
    rdc(7'h03, 8'h04);
    clr(8'h00);
    rdc(7'h03, 8'h00);
    wr(7'h03, 8'h07);
    rdc(7'h03, 8'h04);
    clr(8'h00);
    $display("t_addr done");
  endtask

  task automatic t_sclk();
    frm(16'h0103, 15, 8'h00);
    rdc(7'h03, 8'h02);
    frm(16'h0103, 17, 8'h00);
    swc(8'hFE);
    wr(7'h03, 8'h00);
    rdc(7'h03, 8'h06);
    clr(8'h00);
    // Clear word with one extra clock (17): dropped, and it must not raise the address flag
    frm(16'h6CA9, 17, 8'h00);
    rdc(7'h03, 8'h02);
    clr(8'h00);
    $display("t_sclk done");
  endtask

  task automatic t_cfg();
    wr(7'h02, 8'h00);
    frm(16'h8400, 16, 8'h00);
    frm(16'h8300, 15, 8'h00);
    rdc(7'h03, 8'h00);
    wr(7'h02, 8'hFE);
    rdc(7'h02, 8'h06);
    $display("t_cfg done");
  endtask

  task automatic t_crc();
    wr(7'h02, 8'h07);
    fl = 24;
    rdc(7'h02, 8'h07);
    wr(7'h01, 8'h03);
    swc(8'h03);
    frm(16'h0105, 24, 8'h01);
    swc(8'h03);
    rdc(7'h03, 8'h01);
    frm(16'h0105, 16, 8'h00);
    rdc(7'h03, 8'h03);
    clr(8'h01);
    rdc(7'h03, 8'h03);
    clr(8'h00);
    rdc(7'h03, 8'h00);
    wr(7'h02, 8'h06);
    fl = 16;
    $display("t_crc done");
  endtask

  task automatic t_burst();
    wr(7'h05, 8'h01);
    rdc(7'h05, 8'h01);
    msr_host_i.xfer({16'h0105, 16'h0107, 16'h0000}, 32, r);
    swc(8'h07);
    rdc(7'h03, 8'h00);
    msr_host_i.xfer({16'h0109, 16'h01FF, 16'h0000}, 24, r);
    swc(8'h09);
    rdc(7'h03, 8'h02);
    wr(7'h05, 8'h00);
    rdc(7'h05, 8'h00);
    clr(8'h00);
    $display("t_burst done");
  endtask

  // Reset in mid-run restores the register defaults
  task automatic t_rst();
    wr(7'h01, 8'h0B);
    wr(7'h02, 8'h00);
    @(negedge ref_clk);
    rstn = 1'b0;
    repeat (3) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (4) @(negedge ref_clk);
    swc(8'h00);
    rdc(7'h01, 8'h00);
    rdc(7'h02, 8'h06);
    rdc(7'h03, 8'h00);
    $display("t_rst done");
  endtask

  // Main sequence
  initial begin
    repeat (3) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_reset();
    t_switch();
    t_addr();
    t_sclk();
    t_cfg();
    t_crc();
    t_burst();
    t_rst();
    complete_run();
  end
endmodule
